/* hw/spm_dev.sv */
// Purpose: speed period measurement, filter, fault flash and output shutdown
// Assumes: speed pulse input already synchronous to clk_i
// Notes: one speed input; memory copy is a set of registers on the link
`include "spm_consts.svh"
// ==========
// speed module end
module spm_dev
  import spm_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = `SPM_SAMPLE_CYC,
  parameter logic [31:0] FLASH_ON = `SPM_FLASH_ON_CYC,
  parameter logic [31:0] FLASH_GAP = `SPM_FLASH_GAP_CYC,
  parameter logic [31:0] FLASH_PAUSE = `SPM_FLASH_PAUSE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to host
  spm_if.dev link,
  // field side
  input wire logic speed_pulse_i,
  input wire logic [3:0] ao_src_ok_i,
  input wire logic [3:0] ao_ret_ok_i,
  input wire logic sw_wdog_i,
  input wire logic hw_wdog_i,
  input wire logic bus_wdog_i,
  input wire spm_code_type fault_code_i,
  // indicators and outputs
  output logic fault_led_o,
  output logic [3:0] ao_enable_o,
  output logic [3:0] ao_fault_o
);
  typedef enum logic [1:0] {
    SPM_F_IDLE = 2'b00,
    SPM_F_ON = 2'b01,
    SPM_F_GAP = 2'b10,
    SPM_F_PAUSE = 2'b11
  } spm_flash_type;
  typedef struct packed {
    logic [3:0] psc_cnt;
    logic psc_out;
    logic psc_d;
    logic [31:0] per_cnt;
    logic [31:0] period;
    logic [13:0] tick_cnt;
    logic [31:0] avg0;
    logic [31:0] avg1;
    logic [31:0] avg2;
    logic [31:0] avg3;
    logic [31:0] speed;
    logic [31:0] deriv;
    logic [1:0] range;
    logic [7:0] chan_group;
    logic [31:0] mem_speed;
    logic [31:0] mem_deriv;
    logic [3:0] mem_upd;
    spm_flash_type fst;
    logic [31:0] ftim;
    logic [4:0] fleft;
    logic [4:0] code;
    logic led;
    logic [3:0] ao_en;
    logic [3:0] ao_flt;
  } spm_dev_state_type;
  spm_dev_state_type st, next_st;
  logic [3:0] psc_limit;
  logic [31:0] sum;
  logic wdog;
  // ==========
  // prescale selection and filter sum
  // prescale factor per range: higher speed ranges divide harder
  always_comb begin
    unique case (st.range)
      2'h0: psc_limit = 4'h0;
      2'h1: psc_limit = 4'h1;
      2'h2: psc_limit = 4'h3;
      2'h3: psc_limit = 4'h7;
    endcase
  end
  assign sum = (st.speed >> 2) + (st.avg1 >> 2) + (st.avg2 >> 2) + (st.avg3 >> 2);
  assign wdog = sw_wdog_i | hw_wdog_i | bus_wdog_i;
  // ==========
  // next state
  always_comb begin
    next_st = st;
    // toggle prescaler output every psc_limit+1 input rising edges
    next_st.psc_d = speed_pulse_i;
    if (speed_pulse_i && !st.psc_d) begin
      if (st.psc_cnt >= psc_limit) begin
        next_st.psc_cnt = 4'h0;
        next_st.psc_out = ~st.psc_out;
      end else begin
        next_st.psc_cnt = st.psc_cnt + 4'h1;
      end
    end
    // period counter, latched on each rising prescaled edge
    if (next_st.psc_out && !st.psc_out) begin
      next_st.period = st.per_cnt;
      next_st.per_cnt = 32'h1;
    end else if (st.per_cnt != 32'hffffffff) begin
      next_st.per_cnt = st.per_cnt + 32'h1; // saturate so the first period after a long stall reads slow
    end
    // 100 us sampler with divide, average and derivative
    if (st.tick_cnt == 14'(SAMPLE_CYC - 1)) begin
      next_st.tick_cnt = 14'h0;
      next_st.speed = (st.period == 32'h0) ? 32'h0 : `SPM_SPEED_SCALE / st.period;
      next_st.avg3 = st.avg2;
      next_st.avg2 = st.avg1;
      next_st.avg1 = st.speed;
      next_st.avg0 = sum;
      next_st.deriv = sum - st.avg0;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 14'h1;
    end
    // per channel rate group configuration, range taken from channel 0
    if (link.cfg_valid) begin
      next_st.chan_group[2*link.cfg_chan +: 2] = link.cfg_group[1:0];
      if (link.cfg_chan == 2'h0) begin
        next_st.range = link.cfg_range;
      end
    end
    // key broadcast: copy newest values on every key, flag each due channel
    next_st.mem_upd = 4'h0;
    if (link.key_valid) begin
      for (int c = 0; c < 4; c++) begin
        if (link.key_groups[st.chan_group[2*c +: 2]]) begin
          next_st.mem_upd[c] = 1'b1;
        end
      end
      next_st.mem_speed = st.avg0;
      next_st.mem_deriv = st.deriv;
    end
    // output current check and shutdown
    for (int c = 0; c < 4; c++) begin
      next_st.ao_flt[c] = !(ao_src_ok_i[c] && ao_ret_ok_i[c]);
      next_st.ao_en[c] = !(wdog || fault_code_i != 5'h0);
    end
    // flash code sequencer
    unique case (st.fst)
      SPM_F_IDLE: begin
        next_st.led = 1'b0;
        if (fault_code_i != 5'h0) begin
          next_st.code = fault_code_i;
          next_st.fleft = fault_code_i;
          next_st.fst = SPM_F_ON;
          next_st.ftim = 32'h0;
          next_st.led = 1'b1;
        end
      end
      SPM_F_ON: begin
        next_st.ftim = st.ftim + 32'h1;
        if (st.ftim >= FLASH_ON - 32'h1) begin
          next_st.ftim = 32'h0;
          next_st.led = 1'b0;
          next_st.fleft = st.fleft - 5'h1;
          next_st.fst = (st.fleft == 5'h1) ? SPM_F_PAUSE : SPM_F_GAP;
        end
      end
      SPM_F_GAP: begin
        next_st.ftim = st.ftim + 32'h1;
        if (st.ftim >= FLASH_GAP - 32'h1) begin
          next_st.ftim = 32'h0;
          next_st.led = 1'b1;
          next_st.fst = SPM_F_ON;
        end
      end
      SPM_F_PAUSE: begin
        next_st.ftim = st.ftim + 32'h1;
        if (st.ftim >= FLASH_PAUSE - 32'h1) begin
          next_st.ftim = 32'h0;
          next_st.fst = SPM_F_IDLE;
        end
      end
    endcase
  end
  // ==========
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // ==========
  // outputs, all straight from the state register
  assign link.mem_speed = st.mem_speed;
  assign link.mem_deriv = st.mem_deriv;
  assign link.mem_upd = st.mem_upd;
  assign link.fault_code = st.code;
  assign fault_led_o = st.led;
  assign ao_enable_o = st.ao_en;
  assign ao_fault_o = st.ao_flt;
endmodule

/* hw/spm_consts.svh */
// Purpose: shared constants for the speed measurement and fault report link
// Assumes: 100 MHz module clock
// Notes: sample time is kept in its own unit and its cycle count derives from it; flash times are given directly as cycle counts
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
`define SPM_CLK_MHZ 100
`define SPM_SAMPLE_US 100
`define SPM_SAMPLE_CYC (`SPM_SAMPLE_US * `SPM_CLK_MHZ)
`define SPM_FLASH_ON_CYC 32'd50000000
`define SPM_FLASH_GAP_CYC 32'd50000000
`define SPM_FLASH_PAUSE_CYC 32'd200000000
`define SPM_SPEED_SCALE 32'h05f5e100
`define SPM_CODE_WATCHDOG 5'h01
`define SPM_CODE_CONFIG 5'h0d
`define SPM_CODE_SPEED 5'h13
`define SPM_CODE_DAC_TIMEOUT 5'h16
`define SPM_GROUPS 4
`define SPM_CHANNELS 4
`endif

/* hw/spm_pkg.sv */
// Purpose: types shared by both ends of the speed module link
// Assumes: constants header included alongside
// Notes: only types live here
package spm_pkg;
  typedef logic [4:0] spm_code_type;
  typedef logic [1:0] spm_range_type;
endpackage

/* hw/spm_if.sv */
// Purpose: link between the host cpu end and the speed module end
// Assumes: one clock shared by both ends
// Notes: no clocking block, testbench joins the two ends here
interface spm_if;
  logic cfg_valid;
  logic [1:0] cfg_chan;
  logic [3:0] cfg_group;
  logic [1:0] cfg_range;
  logic key_valid;
  logic [3:0] key_groups;
  logic init_done;
  logic [31:0] mem_speed;
  logic [31:0] mem_deriv;
  logic [3:0] mem_upd;
  logic [4:0] fault_code;
  modport host(output cfg_valid, output cfg_chan, output cfg_group, output cfg_range,
    output key_valid, output key_groups, output init_done,
    input mem_speed, input mem_deriv, input mem_upd, input fault_code);
  modport dev(input cfg_valid, input cfg_chan, input cfg_group, input cfg_range,
    input key_valid, input key_groups, input init_done,
    output mem_speed, output mem_deriv, output mem_upd, output fault_code);
endinterface

/* hw/spm_host.sv */
// Purpose: host cpu end: init, diagnostics, indicators and key broadcast
// Assumes: diagnostics result comes in as plain levels
// Notes: configuration is written one channel per cycle
`include "spm_consts.svh"
module spm_host
  import spm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to module
  spm_if.host link,
  // user side
  input wire logic diag_done_i,
  input wire logic diag_pass_i,
  input wire logic [7:0] chan_group_i,
  input wire spm_range_type range_i,
  input wire logic key_i,
  input wire logic [3:0] key_groups_i,
  output logic fault_led_o,
  output logic run_led_o,
  output logic [31:0] speed_o,
  output logic [31:0] deriv_o
);
  typedef enum logic [1:0] {
    SPM_H_CFG = 2'b00,
    SPM_H_DIAG = 2'b01,
    SPM_H_RUN = 2'b10,
    SPM_H_FAIL = 2'b11
  } spm_host_st_type;
  typedef struct packed {
    spm_host_st_type hs;
    logic [2:0] ch;
    logic cfg_v;
    logic [1:0] cfg_c;
    logic [3:0] cfg_g;
    logic [1:0] cfg_r;
    logic key_v;
    logic [3:0] key_g;
    logic fled;
    logic rled;
    logic [31:0] spd;
    logic [31:0] drv;
  } spm_host_state_type;
  spm_host_state_type st, next_st;
  // ==========
  // sequencer: fault led on from the first clock after reset until diagnostics pass
  always_comb begin
    next_st = st;
    next_st.cfg_v = 1'b0;
    next_st.key_v = 1'b0;
    unique case (st.hs)
      SPM_H_CFG: begin
        next_st.fled = 1'b1;
        if (st.ch == 3'h4) begin
          next_st.hs = SPM_H_DIAG;
        end else begin
          next_st.cfg_v = 1'b1;
          next_st.cfg_c = st.ch[1:0];
          next_st.cfg_r = range_i; // registered so the link sees no raw input
          next_st.cfg_g = {2'h0, chan_group_i[2*st.ch[1:0] +: 2]};
          next_st.ch = st.ch + 3'h1;
        end
      end
      SPM_H_DIAG: begin
        if (diag_done_i) begin
          next_st.hs = diag_pass_i ? SPM_H_RUN : SPM_H_FAIL;
          next_st.fled = !diag_pass_i;
          next_st.rled = diag_pass_i;
        end
      end
      SPM_H_RUN: begin
        next_st.key_v = key_i;
        next_st.key_g = key_groups_i;
        if (link.mem_upd != 4'h0) begin
          next_st.spd = link.mem_speed;
          next_st.drv = link.mem_deriv;
        end
      end
      SPM_H_FAIL: begin
        next_st.fled = 1'b1;
      end
    endcase
  end
  // ==========
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign link.cfg_valid = st.cfg_v;
  assign link.cfg_chan = st.cfg_c;
  assign link.cfg_group = st.cfg_g;
  assign link.cfg_range = st.cfg_r;
  assign link.key_valid = st.key_v;
  assign link.key_groups = st.key_g;
  assign link.init_done = st.rled;
  assign fault_led_o = st.fled;
  assign run_led_o = st.rled;
  assign speed_o = st.spd;
  assign deriv_o = st.drv;
endmodule

/* bench/spm_link_asserts.sv */
// Purpose: timing checks on the link and the module pins
// Assumes: flash on time set to 4 cycles by the bench
// Notes: sees plain signals, no bind
// ==========
// checker
module spm_link_asserts
  import spm_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic cfg_valid,
  input wire logic [1:0] cfg_chan,
  input wire logic key_valid,
  input wire logic init_done,
  input wire logic [31:0] mem_speed,
  input wire logic [3:0] mem_upd,
  // module pins
  input wire logic sw_wdog_i,
  input wire logic hw_wdog_i,
  input wire logic bus_wdog_i,
  input wire spm_code_type fault_code_i,
  input wire logic [3:0] ao_src_ok_i,
  input wire logic [3:0] ao_ret_ok_i,
  input wire logic [3:0] ao_enable_o,
  input wire logic [3:0] ao_fault_o,
  input wire logic fault_led_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rst_q;
  logic [3:0] ok_q;
  // delayed copies, so the edge right after reset is not judged on reset-time inputs
  always_ff @(posedge clk_i) begin
    rst_q <= rst_i;
    ok_q <= ao_src_ok_i & ao_ret_ok_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_upd_needs_key: assert property (!key_valid |=> mem_upd == 4'h0)
    else $error("update without key");
  a_speed_holds: assert property (!key_valid |=> $stable(mem_speed))
    else $error("speed moved between keys");
  a_wdog_shuts: assert property (
    (sw_wdog_i | hw_wdog_i | bus_wdog_i) |=> ao_enable_o == 4'h0)
    else $error("outputs on under watchdog");
  a_code_shuts: assert property (fault_code_i != 5'h00 |=> ao_enable_o == 4'h0)
    else $error("outputs on under fault");
  a_ao_flag: assert property (!rst_q |-> ao_fault_o == ~ok_q)
    else $error("output fault flag wrong");
  a_run_holds: assert property (init_done |=> init_done)
    else $error("run dropped");
  a_cfg_first: assert property (
    rst_q && !rst_i |-> ##[0:4] (cfg_valid && cfg_chan == 2'h0))
    else $error("no config after reset");
  a_key_in_run: assert property (key_valid |-> init_done)
    else $error("key before run");
  a_flash_on: assert property (
    $rose(fault_led_o) |-> fault_led_o [*4] ##1 !fault_led_o)
    else $error("flash length wrong");
  c_key: cover property (mem_upd != 4'h0);
  c_flash: cover property ($rose(fault_led_o));
  c_run: cover property ($rose(init_done));
endmodule

/* bench/tb_top.sv */
// Purpose: both ends joined, user sides driven and checked
// Assumes: short sample and flash counts
// Notes: speed input period 20 cycles
// ==========
// bench
module tb_top
  import spm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic pulse = 1'h0;
  logic diag_done = 1'h0;
  logic diag_pass = 1'h0;
  logic key = 1'h0;
  logic last = 1'h0;
  logic [2:0] wd = 3'h0;
  logic [3:0] kgrp = 4'h0;
  logic [3:0] src = 4'hf;
  logic [3:0] ret = 4'hf;
  spm_code_type code = 5'h00;
  spm_range_type rng = 2'h0;
  logic [7:0] grp = 8'he4;
  logic d_led, h_led, run_led;
  logic [3:0] ao_en, ao_flt;
  logic [31:0] speed, deriv;
  int fails = 0;
  int check_count = 0;
  int n;
  spm_code_type codes [4] = '{5'h01, 5'h0d, 5'h13, 5'h16};
  spm_if link();
  spm_dev #(.SAMPLE_CYC(20), .FLASH_ON(32'h4), .FLASH_GAP(32'h4), .FLASH_PAUSE(32'h10))
    i_spm_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link), .speed_pulse_i(pulse),
    .ao_src_ok_i(src), .ao_ret_ok_i(ret), .sw_wdog_i(wd[0]), .hw_wdog_i(wd[1]),
    .bus_wdog_i(wd[2]), .fault_code_i(code), .fault_led_o(d_led), .ao_enable_o(ao_en),
    .ao_fault_o(ao_flt));
  spm_host i_spm_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .diag_done_i(diag_done),
    .diag_pass_i(diag_pass), .chan_group_i(grp), .range_i(rng), .key_i(key),
    .key_groups_i(kgrp), .fault_led_o(h_led), .run_led_o(run_led), .speed_o(speed),
    .deriv_o(deriv));
  spm_link_asserts i_spm_link_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .cfg_valid(link.cfg_valid), .cfg_chan(link.cfg_chan), .key_valid(link.key_valid),
    .init_done(link.init_done), .mem_speed(link.mem_speed), .mem_upd(link.mem_upd),
    .sw_wdog_i(wd[0]), .hw_wdog_i(wd[1]), .bus_wdog_i(wd[2]), .fault_code_i(code),
    .ao_src_ok_i(src), .ao_ret_ok_i(ret), .ao_enable_o(ao_en), .ao_fault_o(ao_flt),
    .fault_led_o(d_led));
  // clock, and a speed input toggling 1 ns after an edge every 10 cycles
  always #5 clk_i = ~clk_i;
  initial #96 forever #100 pulse = ~pulse;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // reset, then hand the diagnostic result to the host
  task automatic do_reset(input logic pass);
    rst_i = 1'h1;
    diag_pass = pass;
    tick(10);
    rst_i = 1'h0;
    tick(8);
    check({31'h0, h_led}, 32'h1, "fault led at init");
    diag_done = 1'h1;
    tick(4);
    diag_done = 1'h0;
    tick(2);
  endtask
  // one key broadcast: taken at c0, update pulse seen at c1
  task automatic send_key(input logic [3:0] g, input logic [3:0] exp);
    key = 1'h1;
    kgrp = g;
    tick(1);
    key = 1'h0;
    tick(1);
    check({28'h0, link.mem_upd}, {28'h0, exp}, "mem_upd");
  endtask
  initial begin
    do_reset(1'h0);
    check({31'h0, h_led}, 32'h1, "fault led after bad diag");
    check({31'h0, run_led}, 32'h0, "run led after bad diag");
    do_reset(1'h1);
    check({31'h0, h_led}, 32'h0, "fault led after good diag");
    check({31'h0, run_led}, 32'h1, "run led after good diag");
    // input /2 gives a 40 cycle period, so 1e8/40 once the average settles
    tick(400);
    for (int g = 0; g < 4; g++) send_key(4'h1 << g, 4'h1 << g);
    send_key(4'h0, 4'h0);
    send_key(4'h1, 4'h1);
    tick(1);
    check({31'h0, speed > 32'h25c3f8 && speed < 32'h268748}, 32'h1, "speed");
    check(deriv, 32'h0, "deriv");
    for (int i = 0; i < 3; i++) begin
      wd = 3'h1 << i;
      tick(2);
      check({28'h0, ao_en}, 32'h0, "ao_enable wdog");
      wd = 3'h0;
      tick(2);
      check({28'h0, ao_en}, 32'hf, "ao_enable clear");
    end
    src = 4'he;
    tick(2);
    check({28'h0, ao_flt}, 32'h1, "ao_fault src");
    src = 4'hf;
    ret = 4'h7;
    tick(2);
    check({28'h0, ao_flt}, 32'h8, "ao_fault ret");
    ret = 4'hf;
    // count rises over one run plus the start of the pause; a short pause would add one
    // the pause ends 17 cycles after the last flash, then the code starts again
    foreach (codes[i]) begin
      n = 0;
      code = codes[i];
      repeat (8 * codes[i] + 4) begin
        tick(1);
        if (d_led === 1'h1 && !last) n++;
        last = d_led;
      end
      check({28'h0, ao_en}, 32'h0, "ao_enable fault");
      check(32'(n), {27'h0, codes[i]}, "flash count");
      check({27'h0, link.fault_code}, {27'h0, codes[i]}, "fault code");
      tick(9);
      check({31'h0, d_led}, 32'h0, "led in pause");
      tick(1);
      check({31'h0, d_led}, 32'h1, "led repeats");
      code = 5'h00;
      tick(8 * codes[i] + 24);
      last = d_led;
    end
    // range 1 divides by 4: 80 cycle period; reversed map puts channel 0 in group 3
    rng = 2'h1;
    grp = 8'h1b;
    do_reset(1'h1);
    tick(600);
    send_key(4'h1, 4'h8);
    send_key(4'h8, 4'h1);
    tick(1);
    check(speed, 32'h001312d0, "speed range 1");
    give_verdict();
  end
  // cut a hang well beyond the few thousand cycles the tests take
  initial begin
    #50us;
    fails++;
    give_verdict();
  end
endmodule
